/* verilog/pps_port.sv */
// Control port of a pipelined burst SRAM, 2M words of 36 bits
//
// What this block does
// - Address registered only on an accepted strobe with all chip selects active
// - Accepted strobe loads full address and preloads the burst counter
// - Both strobes low with primary select low: processor strobe alone is acted upon
// - Processor strobe ignored while primary chip select is high
// - Primary and third selects active low, second active high, all needed
// - Chip selects looked at only when a new address loads
// - Burst counter steps on each edge with advance low in a burst
// - Global write low writes every lane, whatever the lane controls
// - Lane write enable low writes just the lanes whose select is low
// - Lane selects registered at the edge, used only with lane enable
// - All synchronous inputs captured on the rising clock edge
// - Data pins driven while output enable low, released while high
// - Pins stay released on the first read clock after deselect
// - Controller strobe also loads address and preloads burst counter
// - Burst order strap: low linear, high interleaved, kept static
// - Sleep input high halts activity and keeps the stored words
// - Read data appears one clock after its address edge
`timescale 1ns/1ps
module pps_port (
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [pps_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic PROCESSOR_ADDR_STROBE_N_IN,
	input wire logic CONTROLLER_ADDR_STROBE_N_IN,
	input wire logic BURST_ADVANCE_N_IN,
	input wire logic ALL_LANES_WRITE_N_IN,
	input wire logic LANE_WRITE_ENABLE_N_IN,
	input wire logic [pps_pkg::LANE_CNT-1:0] LANE_SELECT_N_IN,
	input wire logic CHIP_SEL_PRIMARY_N_IN,
	input wire logic CHIP_SEL_SECOND_IN,
	input wire logic CHIP_SEL_THIRD_N_IN,
	input wire logic OUTPUT_ENABLE_N_IN,
	input wire logic SLEEP_REQUEST_IN,
	input wire logic BURST_ORDER_IN,
	input wire logic [pps_pkg::DATA_W-1:0] DATA_IN,
	output logic [pps_pkg::DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_OUT
);
	import pps_pkg::*;

	pps_state_s state_reg;
	pps_state_s state_next;
	logic proc_take;
	logic ctrl_take;
	logic addr_load;
	logic selected;
	logic first_read;
	logic [LANE_CNT-1:0] lane_mask;
	logic [BURST_W-1:0] burst_low;

	pps_mem_if mem_bus ();

	////////////////////////////////////////////////////////////////////////
	// Strobe arbitration and chip select decode
	// Processor strobe counts only with the primary select low
	assign proc_take = !PROCESSOR_ADDR_STROBE_N_IN &&
		!CHIP_SEL_PRIMARY_N_IN;
	// Controller strobe loses whenever the processor strobe is taken
	assign ctrl_take = !CONTROLLER_ADDR_STROBE_N_IN && !proc_take;
	assign addr_load = proc_take || ctrl_take;
	// Selected only with all three selects at their active levels
	assign selected = !CHIP_SEL_PRIMARY_N_IN && CHIP_SEL_SECOND_IN &&
		!CHIP_SEL_THIRD_N_IN;

	////////////////////////////////////////////////////////////////////////
	// Lanes to write this cycle
	always_comb begin
		if (!ALL_LANES_WRITE_N_IN) begin
			lane_mask = LANES_ALL;
		end else if (!LANE_WRITE_ENABLE_N_IN) begin
			lane_mask = ~LANE_SELECT_N_IN;
		end else begin
			lane_mask = LANES_NONE;
		end
	end

	// A read that starts from the deselected state
	assign first_read = addr_load && selected && !state_reg.active &&
		(lane_mask == LANES_NONE) && !state_reg.sleep_sync;

	////////////////////////////////////////////////////////////////////////
	// Next state: everything synchronous is taken from the pins here
	always_comb begin
		state_next = state_reg;
		// Asynchronous pins pass two flops before any logic sees them
		state_next.oe_n_meta = OUTPUT_ENABLE_N_IN;
		state_next.oe_n_sync = state_reg.oe_n_meta;
		state_next.sleep_meta = SLEEP_REQUEST_IN;
		state_next.sleep_sync = state_reg.sleep_meta;
		state_next.mode_meta = BURST_ORDER_IN;
		state_next.mode_sync = state_reg.mode_meta;
		state_next.acc_en = 1'b0;
		state_next.wr_lanes = LANES_NONE;
		state_next.wdata = DATA_IN;
		// Sleep freezes the burst state; the array is left untouched
		if (!state_reg.sleep_sync) begin
			if (addr_load) begin
				// Selects only matter on an address load
				state_next.active = selected;
				if (selected) begin
					state_next.addr_hi = ADDR_IN[ADDR_W-1:BURST_W];
					state_next.start_low = ADDR_IN[BURST_W-1:0];
					state_next.beat = BURST_RST;
				end
			end else if (state_reg.active && !BURST_ADVANCE_N_IN) begin
				// Two-bit beat count wraps by itself after four beats
				state_next.beat = state_reg.beat + BURST_STEP;
			end
			state_next.acc_en = state_next.active;
			if (state_next.active) begin
				state_next.wr_lanes = lane_mask;
			end
		end
		// Driving follows output enable, masked at a fresh read start
		state_next.drive = !state_reg.oe_n_sync && !first_read &&
			!state_reg.sleep_sync;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; no pin value is loaded under reset
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg.oe_n_meta <= 1'b1;
			state_reg.oe_n_sync <= 1'b1;
			state_reg.sleep_meta <= 1'b0;
			state_reg.sleep_sync <= 1'b0;
			state_reg.mode_meta <= MODE_RST;
			state_reg.mode_sync <= MODE_RST;
			state_reg.active <= 1'b0;
			state_reg.addr_hi <= ADDR_HI_RST;
			state_reg.start_low <= BURST_RST;
			state_reg.beat <= BURST_RST;
			state_reg.acc_en <= 1'b0;
			state_reg.wr_lanes <= LANES_NONE;
			state_reg.wdata <= DATA_RST;
			state_reg.drive <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Burst order; the strap is assumed static, so no glitch guard
	always_comb begin
		if (state_reg.mode_sync) begin
			burst_low = state_reg.start_low ^ state_reg.beat;
		end else begin
			burst_low = state_reg.start_low + state_reg.beat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array access one edge after the address was captured
	assign mem_bus.en = state_reg.acc_en;
	assign mem_bus.wr_lanes = state_reg.wr_lanes;
	assign mem_bus.addr = {state_reg.addr_hi, burst_low};
	assign mem_bus.wdata = state_reg.wdata;

	pps_mem_array u_mem (
		.clk_in(CORE_CLK_IN),
		.port(mem_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs, both straight from flops
	assign DATA_OUT = mem_bus.rdata;
	assign DATA_OE_OUT = state_reg.drive;

	////////////////////////////////////////////////////////////////////////
	// Checks on the captured state and the pin drive
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	// Address and counter preload on an accepted, selected strobe
	a_addr_capture_load: assert property (
		(addr_load && selected && !state_reg.sleep_sync) |=>
		(state_reg.addr_hi == $past(ADDR_IN[ADDR_W-1:BURST_W]) &&
		state_reg.start_low == $past(ADDR_IN[BURST_W-1:0]) &&
		state_reg.beat == BURST_RST && state_reg.acc_en))
		else $error("address not captured on accepted strobe");

	// An inactive select on a load deselects, with no access
	a_select_gate_load: assert property (
		(addr_load && !selected && !state_reg.sleep_sync) |=>
		(!state_reg.active && !state_reg.acc_en))
		else $error("access started without all chip selects");

	// Second select is active high: low means deselect
	a_second_select_level: assert property (
		(addr_load && !CHIP_SEL_SECOND_IN && !state_reg.sleep_sync) |=>
		!state_reg.active)
		else $error("second chip select level wrong");

	// Both strobes low: outcome is the processor strobe's
	a_proc_strobe_wins: assert property (
		(!PROCESSOR_ADDR_STROBE_N_IN && !CONTROLLER_ADDR_STROBE_N_IN &&
		!CHIP_SEL_PRIMARY_N_IN && !state_reg.sleep_sync) |=>
		(state_reg.active == $past(selected)))
		else $error("controller strobe acted with processor strobe low");

	// Processor strobe with primary select high loads nothing
	a_proc_ignored_cs: assert property (
		(!PROCESSOR_ADDR_STROBE_N_IN && CHIP_SEL_PRIMARY_N_IN &&
		CONTROLLER_ADDR_STROBE_N_IN) |=>
		($stable(state_reg.active) && $stable(state_reg.addr_hi)))
		else $error("processor strobe taken with primary select high");

	// Controller strobe loads the counter too
	a_ctrl_strobe_load: assert property (
		(PROCESSOR_ADDR_STROBE_N_IN && !CONTROLLER_ADDR_STROBE_N_IN &&
		selected && !state_reg.sleep_sync) |=>
		(state_reg.start_low == $past(ADDR_IN[BURST_W-1:0])))
		else $error("controller strobe did not preload counter");

	// Burst cycles carry on whatever the select pins do
	a_burst_select_free: assert property (
		(!addr_load && state_reg.active && !state_reg.sleep_sync) |=>
		(state_reg.active && state_reg.acc_en))
		else $error("burst dropped on select pins");

	// One beat per advance, wrapping modulo four, upper bits held
	a_burst_advance_step: assert property (
		(!addr_load && state_reg.active && !BURST_ADVANCE_N_IN &&
		!state_reg.sleep_sync) |=>
		(state_reg.beat == $past(state_reg.beat) + BURST_STEP &&
		$stable(state_reg.addr_hi)))
		else $error("burst counter did not advance");

	// Four advances bring the beat back to where it started
	a_burst_wrap_four: assert property (
		(!addr_load && state_reg.active && !state_reg.sleep_sync &&
		state_reg.beat == BURST_RST && !BURST_ADVANCE_N_IN) ##1
		(!addr_load && !BURST_ADVANCE_N_IN && !state_reg.sleep_sync)
		[*3] |=> (state_reg.beat == BURST_RST))
		else $error("burst counter did not wrap after four beats");

	// Global write covers every lane
	a_global_write_all: assert property (
		(addr_load && selected && !ALL_LANES_WRITE_N_IN &&
		!state_reg.sleep_sync) |=> (state_reg.wr_lanes == LANES_ALL))
		else $error("global write missed a lane");

	// Lane write follows the lane selects of the same edge
	a_lane_write_mask: assert property (
		(addr_load && selected && ALL_LANES_WRITE_N_IN &&
		!LANE_WRITE_ENABLE_N_IN && !state_reg.sleep_sync) |=>
		(state_reg.wr_lanes == ~$past(LANE_SELECT_N_IN)))
		else $error("lane write mask wrong");

	// Lane selects alone never write
	a_lane_needs_enable: assert property (
		(ALL_LANES_WRITE_N_IN && LANE_WRITE_ENABLE_N_IN) |=>
		(state_reg.wr_lanes == LANES_NONE))
		else $error("lane written without lane enable");

	// Released pins while output enable stays high
	a_output_release: assert property (
		state_reg.oe_n_sync |=> !DATA_OE_OUT)
		else $error("pins driven with output enable high");

	// Fresh read after deselect keeps the pins released
	a_first_read_mask: assert property (
		first_read |=> !DATA_OE_OUT)
		else $error("pins driven on first read clock");

	// Sleep stops accesses and holds the address
	a_sleep_hold_state: assert property (
		state_reg.sleep_sync |=>
		(!state_reg.acc_en && $stable(state_reg.addr_hi)))
		else $error("activity during sleep");

	// Write data is taken at the same edge as the write address
	a_write_data_edge: assert property (
		(addr_load && selected && !ALL_LANES_WRITE_N_IN &&
		!state_reg.sleep_sync) |=> (state_reg.wdata == $past(DATA_IN)))
		else $error("write data not taken at the address edge");

	// Pins driven while the synced enable is low, outside the masks
	a_output_drive: assert property (
		(!state_reg.oe_n_sync && !first_read &&
		!state_reg.sleep_sync) |=>
		DATA_OE_OUT)
		else $error("pins released with output enable low");

	// Interleaved step: low bit always flips, upper bit on odd beats
	a_order_interleave: assert property (
		(!addr_load && state_reg.active && !BURST_ADVANCE_N_IN &&
		state_reg.mode_sync && !state_reg.sleep_sync) |=>
		(burst_low[0] != $past(burst_low[0]) &&
		(burst_low[1] != $past(burst_low[1])) ==
		$past(state_reg.beat[0])))
		else $error("interleaved burst order wrong");

	// Linear step: the low address bits count up by one and wrap
	a_order_linear: assert property (
		(!addr_load && state_reg.active && !BURST_ADVANCE_N_IN &&
		!state_reg.mode_sync && !state_reg.sleep_sync) |=>
		(burst_low == $past(burst_low) + BURST_STEP))
		else $error("linear burst order wrong");

endmodule // pps_port

/* verilog/pps_pkg.sv */
// Shared constants and state type of the pipelined sync SRAM port
package pps_pkg;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int ADDR_W = 21;
	localparam int DATA_W = 36;
	localparam int LANE_CNT = 4;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int BURST_W = 2;
	localparam int PARITY_POS = 32;
	localparam int MEM_DEPTH = 2 ** ADDR_W;
	localparam int HI_W = ADDR_W - BURST_W;

	////////////////////////////////////////////////////////////////////////
	// Values after reset and fixed encodings
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [HI_W-1:0] ADDR_HI_RST = 19'h0;
	localparam logic [LANE_CNT-1:0] LANES_ALL = 4'hF;
	localparam logic [LANE_CNT-1:0] LANES_NONE = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
	localparam logic MODE_RST = 1'h1;

	////////////////////////////////////////////////////////////////////////
	// All control state of the port
	typedef struct packed {
		logic oe_n_meta;
		logic oe_n_sync;
		logic sleep_meta;
		logic sleep_sync;
		logic mode_meta;
		logic mode_sync;
		logic active;
		logic [HI_W-1:0] addr_hi;
		logic [BURST_W-1:0] start_low;
		logic [BURST_W-1:0] beat;
		logic acc_en;
		logic [LANE_CNT-1:0] wr_lanes;
		logic [DATA_W-1:0] wdata;
		logic drive;
	} pps_state_s;

endpackage

/* verilog/pps_mem_if.sv */
// Carrier between the port control logic and the storage array
`timescale 1ns/1ps
interface pps_mem_if;
	import pps_pkg::*;

	logic en;
	logic [LANE_CNT-1:0] wr_lanes;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport ctl (output en, output wr_lanes, output addr, output wdata,
		input rdata);
	modport mem (input en, input wr_lanes, input addr, input wdata,
		output rdata);
endinterface

/* verilog/pps_mem_array.sv */
// Storage array with per-lane writes and a registered read
`timescale 1ns/1ps
module pps_mem_array (
	input wire logic clk_in,
	pps_mem_if.mem port
);
	import pps_pkg::*;

	logic [LANE_W-1:0] lane_rd [LANE_CNT];

	////////////////////////////////////////////////////////////////////////
	// One array per lane keeps every lane on its own driver
	for (genvar i = 0; i < LANE_CNT; i++) begin : g_lane
		logic [LANE_W-1:0] lane_mem [MEM_DEPTH];
		logic [LANE_W-1:0] lane_wd;

		// Eight data bits and the lane's parity bit form one lane
		assign lane_wd = {port.wdata[PARITY_POS+i],
			port.wdata[BYTE_W*i +: BYTE_W]};

		// A read only on cycles that write no lane; data shows next cycle
		always_ff @(posedge clk_in) begin
			if (port.en && port.wr_lanes[i]) begin
				lane_mem[port.addr] <= lane_wd;
			end
			if (port.en && (port.wr_lanes == LANES_NONE)) begin
				lane_rd[i] <= lane_mem[port.addr];
			end
		end

		// Read word reassembled in the pin order
		assign port.rdata[BYTE_W*i +: BYTE_W] = lane_rd[i][BYTE_W-1:0];
		assign port.rdata[PARITY_POS+i] = lane_rd[i][BYTE_W];
	end
endmodule // pps_mem_array

/* testbench/pps_bus_master.sv */
// Bus master model that drives the synchronous pins of the SRAM port
`timescale 1ns/1ps
module pps_bus_master (
	input wire logic clk_in,
	output logic [pps_pkg::ADDR_W-1:0] addr_out,
	output logic processor_addr_strobe_n_out,
	output logic controller_addr_strobe_n_out,
	output logic burst_advance_n_out,
	output logic all_lanes_write_n_out,
	output logic lane_write_enable_n_out,
	output logic [pps_pkg::LANE_CNT-1:0] lane_select_n_out,
	output logic [2:0] chip_sel_out,
	output logic [pps_pkg::DATA_W-1:0] data_out
);
	import pps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero, device selected
	initial begin
		addr_out = '0;
		processor_addr_strobe_n_out = 1'h1;
		controller_addr_strobe_n_out = 1'h1;
		burst_advance_n_out = 1'h1;
		all_lanes_write_n_out = 1'h1;
		lane_write_enable_n_out = 1'h1;
		lane_select_n_out = LANES_ALL;
		chip_sel_out = 3'h2;
		data_out = DATA_RST;
	end

	////////////////////////////////////////////////////////////////////////
	// One bus cycle, changed just after the edge and held for a full cycle
	task automatic cyc(input logic ps_n, input logic cs_n,
			input logic advance_n, input logic all_wr_n,
			input logic lane_we_n,
			input logic [LANE_CNT-1:0] lane_sel_n, input logic [2:0] sel,
			input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		addr_out <= a;
		processor_addr_strobe_n_out <= ps_n;
		controller_addr_strobe_n_out <= cs_n;
		burst_advance_n_out <= advance_n;
		all_lanes_write_n_out <= all_wr_n;
		lane_write_enable_n_out <= lane_we_n;
		lane_select_n_out <= lane_sel_n;
		chip_sel_out <= sel;
		// Released lines toggle so a stale value can never look right
		data_out <= (!all_wr_n || !lane_we_n) ? d : ~data_out;
	endtask
endmodule // pps_bus_master

/* testbench/tb.sv */
// Self-checking bench for the pipelined sync SRAM port
`timescale 1ns/1ps
module tb;
	import pps_pkg::*;

	localparam logic [2:0] SEL_ON = 3'h2;
	localparam logic [2:0] SEL_OFF = 3'h5;
	localparam logic [ADDR_W-1:0] A_W = 21'h1ABCD;
	localparam logic [ADDR_W-1:0] A_L = 21'h00042;
	localparam logic [DATA_W-1:0] D_BEAT = 36'hC_0000_0000;

	logic clk, rst_n, oe_n, sleep, order, ps_n, cs_n, advance_n, all_wr_n;
	logic lane_we_n;
	logic doe;
	logic [ADDR_W-1:0] addr;
	logic [LANE_CNT-1:0] lane_sel_n;
	logic [2:0] sel;
	logic [DATA_W-1:0] din, dout;
	int n_mismatch, n_compared;

	pps_bus_master u_master (.clk_in(clk), .addr_out(addr),
		.processor_addr_strobe_n_out(ps_n),
		.controller_addr_strobe_n_out(cs_n),
		.burst_advance_n_out(advance_n),
		.all_lanes_write_n_out(all_wr_n),
		.lane_write_enable_n_out(lane_we_n),
		.lane_select_n_out(lane_sel_n), .chip_sel_out(sel), .data_out(din));

	pps_port i_pps_port (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
		.ADDR_IN(addr), .PROCESSOR_ADDR_STROBE_N_IN(ps_n),
		.CONTROLLER_ADDR_STROBE_N_IN(cs_n),
		.BURST_ADVANCE_N_IN(advance_n),
		.ALL_LANES_WRITE_N_IN(all_wr_n),
		.LANE_WRITE_ENABLE_N_IN(lane_we_n),
		.LANE_SELECT_N_IN(lane_sel_n), .CHIP_SEL_PRIMARY_N_IN(sel[2]),
		.CHIP_SEL_SECOND_IN(sel[1]), .CHIP_SEL_THIRD_N_IN(sel[0]),
		.OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep),
		.BURST_ORDER_IN(order), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OE_OUT(doe));

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input string what, input logic [DATA_W-1:0] e,
			input logic [DATA_W-1:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
			input logic [DATA_W-1:0] n, input logic [LANE_CNT-1:0] m);
		merge = o;
		for (int i = 0; i < LANE_CNT; i++) begin
			if (!m[i]) begin
				merge[i*BYTE_W +: BYTE_W] = n[i*BYTE_W +: BYTE_W];
				merge[PARITY_POS+i] = n[PARITY_POS+i];
			end
		end
	endfunction

	task automatic idle();
		u_master.cyc(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, LANES_ALL, SEL_ON, '0, '0);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		u_master.cyc(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, LANES_ALL, SEL_ON, a, d);
	endtask

	// Data is looked at one full cycle after the address edge
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		u_master.cyc(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, LANES_ALL, SEL_ON, a, '0);
		idle();
		idle();
		#1;
		chk("read word", e, dout);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_write_all();
		wr(A_W, 36'h9_8765_4321);
		rd(A_W, 36'h9_8765_4321);
		u_master.cyc(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, LANES_ALL, SEL_ON, A_W,
			36'h1_0F0F_0F0F);
		rd(A_W, 36'h1_0F0F_0F0F);
		// Both strobes low: the processor strobe's write goes through
		u_master.cyc(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, LANES_ALL, SEL_ON, A_L,
			36'h2_0000_0003);
		rd(A_L, 36'h2_0000_0003);
	endtask

	task automatic s_lanes();
		logic [LANE_CNT-1:0] pats [3] = '{4'hA, 4'h6, 4'h0};
		foreach (pats[k]) begin
			wr(A_L, 36'hF_FFFF_FFFF);
			u_master.cyc(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, pats[k], SEL_ON, A_L,
				36'h5_A55A_3CC3);
			rd(A_L, merge(36'hF_FFFF_FFFF, 36'h5_A55A_3CC3, pats[k]));
		end
		// Lane picks alone, without the lane enable, must write nothing
		u_master.cyc(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, LANES_NONE, SEL_ON, A_L,
			'0);
		rd(A_L, 36'h5_A55A_3CC3);
	endtask

	task automatic s_selects();
		logic [3:0] tries [4] = '{4'h6, 4'h8, 4'hB, 4'hE};
		logic [DATA_W-1:0] exp_word;
		foreach (tries[k]) begin
			wr(A_L, 36'h0_1111_2222);
			u_master.cyc(tries[k][3], !tries[k][3], 1'h1, 1'h0, 1'h1,
				LANES_ALL, tries[k][2:0], A_L, 36'hE_EEEE_EEEE);
			// An ignored strobe continues the open access and writes it
			exp_word = 36'h0_1111_2222;
			if (!tries[k][3]) begin
				exp_word = 36'hE_EEEE_EEEE;
			end
			rd(A_L, exp_word);
		end
	endtask

	task automatic s_burst();
		logic [1:0] low;
		for (int i = 0; i < 4; i++) begin
			wr(21'h155A0 + ADDR_W'(i), D_BEAT + DATA_W'(i));
		end
		for (int m = 0; m < 2; m++) begin
			idle();
			order <= (m == 0);
			repeat (3) idle();
			u_master.cyc(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, LANES_ALL, SEL_ON,
				21'h155A1, '0);
			for (int k = 0; k <= 4; k++) begin
				// Selects off and address cleared while the burst runs
				u_master.cyc(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, LANES_ALL, SEL_OFF,
					'0, '0);
				if (k > 0) begin
					#1;
					low = order ? 2'(1 ^ (k - 1)) : 2'(k);
					chk("burst beat", D_BEAT + DATA_W'(low), dout);
				end
			end
		end
	endtask

	task automatic s_sleep();
		idle();
		sleep <= 1'h1;
		repeat (3) idle();
		wr(A_W, 36'h0_DEAD_0000);
		idle();
		sleep <= 1'h0;
		repeat (3) idle();
		rd(A_W, 36'h1_0F0F_0F0F);
	endtask

	task automatic s_oe();
		idle();
		oe_n <= 1'h0;
		repeat (3) idle();
		u_master.cyc(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, LANES_ALL, SEL_OFF, '0, '0);
		u_master.cyc(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, LANES_ALL, SEL_ON, A_W, '0);
		idle();
		#1;
		chk("first read drive", '0, DATA_W'(doe));
		idle();
		#1;
		chk("read drive", 36'h1, DATA_W'(doe));
		idle();
		oe_n <= 1'h1;
		repeat (3) idle();
		#1;
		chk("released drive", '0, DATA_W'(doe));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the watchdog
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Free-running clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Main sequence; reset spans two cycles
	initial begin
		rst_n = 1'h0;
		oe_n = 1'h1;
		sleep = 1'h0;
		order = 1'h1;
		n_mismatch = 0;
		n_compared = 0;
		@(posedge clk);
		#1;
		chk("reset drive", '0, DATA_W'(doe));
		@(posedge clk);
		rst_n <= 1'h1;
		s_write_all();
		s_lanes();
		s_selects();
		s_burst();
		s_sleep();
		s_oe();
		report_and_stop();
	end

	// Tests need about a hundred cycles; far beyond that is a hang
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule // tb
